/* rtl/clk_out_divider.sv */
`include "synth_div_cfg.svh"

module clk_out_divider #(
    parameter int HALF_W = 7
) (
    input  wire logic              clock_in,
    input  wire logic              rst_n_in,
    input  wire logic              tick_in,
    input  wire logic [HALF_W-1:0] half_in,
    input  wire logic              gate_in,
    output logic                   out_p_out,
    output logic                   out_n_out
);

    logic [HALF_W-1:0] cnt_ff;
    logic              wrap;

    // A half period ends after half_in source ticks
    assign wrap = tick_in && (HALF_W'(cnt_ff + 1'b1) >= half_in);

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_ff <= '0;
        end else if (wrap) begin
            cnt_ff <= '0;
        end else if (tick_in) begin
            cnt_ff <= HALF_W'(cnt_ff + 1'b1);
        end
    end

    // Gate is looked at only at the output's own low boundary, so a high phase
    // always runs to full length and no runt pulse can appear
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            out_p_out <= 1'b0;
            out_n_out <= 1'b1;
        end else if (wrap) begin
            if (out_p_out) begin
                out_p_out <= 1'b0;
                out_n_out <= 1'b1;
            end else begin
                out_p_out <= gate_in;
                out_n_out <= !gate_in;
            end
        end
    end

    AST_START_ONLY_WHEN_GATED: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        $rose(out_p_out) |-> $past(gate_in) && $past(wrap))
        else $error("output started without its gate at a boundary");

    AST_PAIR_OPPOSITE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        out_p_out != out_n_out)
        else $error("differential pair lost complement");

endmodule

/* rtl/loop_lock_detect.sv */
`include "synth_div_cfg.svh"

module loop_lock_detect #(
    parameter int CONFIRM = `SD_LOCK_CONFIRM
) (
    input  wire logic       clock_in,
    input  wire logic       rst_n_in,
    input  wire logic       ref_tick_in,
    input  wire logic       vco_tick_in,
    input  wire logic       pre_sel_in,
    input  wire logic [9:0] feedback_in,
    output logic            locked_out,
    output logic            fb_phase_out
);

    logic [1:0]                   pre_cnt_ff;
    logic [9:0]                   fb_cnt_ff;
    logic [1:0]                   seen_ff;
    logic [$clog2(CONFIRM+1)-1:0] good_ff;
    synth_div_pkg::lock_state_t   state_ff;
    logic                         ref_div_tick;
    logic                         fb_tick;
    logic                         match;

    assign ref_div_tick = ref_tick_in &&
        (pre_cnt_ff == (pre_sel_in ? `SD_PRE_LAST_DIV4 : `SD_PRE_LAST_DIV2));
    // A feedback value of zero behaves as divide by one
    assign fb_tick = vco_tick_in && (10'(fb_cnt_ff + 1'b1) >= feedback_in);
    assign match   = ref_div_tick && (seen_ff == 2'h1);

    // Pre-divided reference and feedback-divided oscillator
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pre_cnt_ff   <= '0;
            fb_cnt_ff    <= '0;
            fb_phase_out <= 1'b0;
        end else begin
            if (ref_div_tick) begin
                pre_cnt_ff <= '0;
            end else if (ref_tick_in) begin
                pre_cnt_ff <= 2'(pre_cnt_ff + 1'b1);
            end
            if (fb_tick) begin
                fb_cnt_ff    <= '0;
                fb_phase_out <= !fb_phase_out;
            end else if (vco_tick_in) begin
                fb_cnt_ff <= 10'(fb_cnt_ff + 1'b1);
            end
        end
    end

    // Exactly one feedback edge per reference window counts as a match
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            seen_ff <= '0;
        end else if (ref_div_tick) begin
            seen_ff <= {1'b0, fb_tick};
        end else if (fb_tick && seen_ff != 2'h3) begin
            seen_ff <= 2'(seen_ff + 1'b1);
        end
    end

    // Lock is shown only after a run of matching windows; any miss drops it
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_ff   <= synth_div_pkg::LOCK_SEARCH;
            good_ff    <= '0;
            locked_out <= 1'b0;
        end else if (ref_div_tick) begin
            case (state_ff)
                synth_div_pkg::LOCK_SEARCH: begin
                    if (!match) begin
                        good_ff <= '0;
                    end else if (good_ff == ($clog2(CONFIRM+1))'(CONFIRM - 1)) begin
                        state_ff   <= synth_div_pkg::LOCK_HELD;
                        locked_out <= 1'b1;
                    end else begin
                        good_ff <= ($clog2(CONFIRM+1))'(good_ff + 1'b1);
                    end
                end
                synth_div_pkg::LOCK_HELD: begin
                    if (!match) begin
                        state_ff   <= synth_div_pkg::LOCK_SEARCH;
                        good_ff    <= '0;
                        locked_out <= 1'b0;
                    end
                end
                default: begin
                    state_ff   <= synth_div_pkg::LOCK_SEARCH;
                    locked_out <= 1'b0;
                end
            endcase
        end
    end

    AST_LOCK_FROM_MATCH: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        $rose(locked_out) |-> $past(match))
        else $error("lock shown without a matching window");

    AST_UNLOCK_ON_MISS: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (ref_div_tick && !match) |=> !locked_out)
        else $error("lock held through a missed window");

endmodule

/* rtl/synth_div_cfg.svh */
`ifndef SYNTH_DIV_CFG_SVH
`define SYNTH_DIV_CFG_SVH

// Register addresses
`define SD_ADDR_CFG_LOW    8'h00
`define SD_ADDR_CFG_HIGH   8'h01
`define SD_ADDR_SIGNATURE  8'h08
`define SD_ADDR_COMMAND    8'hF0

// Register reset values
`define SD_CFG_LOW_RST     8'hF4
`define SD_CFG_HIGH_RST    8'h52
// Signature value is arbitrary
`define SD_SIGNATURE_VAL   8'hA5
`define SD_RDATA_NONE      8'h00

// High configuration register field positions
`define SD_HI_M_MSB        7
`define SD_HI_M_LSB        6
`define SD_HI_NA_MSB       5
`define SD_HI_NA_LSB       3
`define SD_HI_NB           2
`define SD_HI_P            1
`define SD_HI_LOCK         0

// Command codes, low nibble of the command register
`define SD_CMD_STEP_UP     4'h1
`define SD_CMD_STEP_DOWN   4'h2
`define SD_CMD_LOAD        4'h4
`define SD_CMD_CAPTURE     4'h8

// Active divider reset values
`define SD_M_RST           10'h1F4
`define SD_NA_RST          3'h2
`define SD_NB_RST          1'b0
`define SD_P_RST           1'b1

// Post-divider code limit (code 5 gives divide by 64)
`define SD_NA_CODE_MAX     3'h5
// Pre-divider terminal counts for divide by 2 and by 4
`define SD_PRE_LAST_DIV2   2'h1
`define SD_PRE_LAST_DIV4   2'h3
// Matching comparison windows needed before lock is shown
`define SD_LOCK_CONFIRM    8

`endif

/* rtl/synth_div_pkg.sv */
package synth_div_pkg;

    // Lock detector states
    typedef enum logic [0:0] {
        LOCK_SEARCH = 1'b0,
        LOCK_HELD   = 1'b1
    } lock_state_t;

endpackage

/* rtl/synth_divider_output_control.sv */
// Contract
// - Bypass low: outputs divide the reference by post-dividers only.
// - Loop active: primary = ref / pre * feedback / primary post-divider.
// - In bypass the lock output carries a test signal instead.
// - Factory mode select 0 is normal operation; 1 enables test mode.
// - Gate low stops that output and holds it low; high runs it.
// - Each gate is synchronised to its own output clock; no runt pulses.
// - Master reset low forces outputs low asynchronously.
// - Master reset release loads all dividers from parallel pins, any source.
// - After master reset release the loop starts acquiring lock.
// - Outside bypass and factory test mode, lock output is 1 only when locked, 0 otherwise.
// - Lock compares feedback-divided oscillator with pre-divided reference.
// - Source select chooses parallel pins or serial registers for dividers.
// - Serial access reads and writes configuration registers.
// - Four 8-bit registers: two configuration, command, signature.
// - Secondary select gives secondary output 1x or 1/2x primary.
// - Source 1: dividers via serial after the master reset startup load; source 0: follow pins.
// - In parallel mode the host can still read current dividers.
// - Commands: step up, step down, load, capture active dividers.
`include "synth_div_cfg.svh"

module synth_divider_output_control #(
    parameter int LOCK_CONFIRM = `SD_LOCK_CONFIRM
) (
    input  wire logic       clock_in,
    input  wire logic       rst_n_in,
    input  wire logic       master_reset_n_in,
    input  wire logic       bypass_n_in,
    input  wire logic       factory_test_in,
    input  wire logic       config_source_sel_in,
    input  wire logic [1:0] output_gate_n_in,
    input  wire logic       ref_clk_in,
    input  wire logic       vco_clk_in,
    input  wire logic [9:0] pin_feedback_in,
    input  wire logic [2:0] pin_primary_post_divider_in,
    input  wire logic       pin_secondary_post_divider_in,
    input  wire logic       pin_pre_divider_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    output logic [7:0]      reg_rdata_out,
    output logic            reg_rvalid_out,
    output logic            primary_out_pair_p_out,
    output logic            primary_out_pair_n_out,
    output logic            secondary_out_pair_p_out,
    output logic            secondary_out_pair_n_out,
    output logic            lock_out,
    output logic            test_mode_out,
    output logic [9:0]      active_feedback_out,
    output logic [2:0]      active_primary_post_divider_out,
    output logic            active_secondary_post_divider_out,
    output logic            active_pre_divider_out
);

    // Two-stage synchronisers for every pin; stage one feeds stage two only
    localparam int SYNC_W = 23;
    logic [SYNC_W-1:0] pin_s1_ff;
    logic [SYNC_W-1:0] pin_s2_ff;
    logic              ref_s3_ff;
    logic              vco_s3_ff;
    logic              mr_s3_ff;
    logic [9:0]        sync_m;
    logic [2:0]        sync_na;
    logic              sync_nb;
    logic              sync_p;
    logic              sync_src_sel;
    logic              sync_bypass_n;
    logic              sync_test;
    logic [1:0]        sync_gate;
    logic              sync_mr_n;
    logic              sync_ref;
    logic              sync_vco;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
        end else begin
            pin_s1_ff <= {pin_feedback_in, pin_primary_post_divider_in, pin_secondary_post_divider_in,
                          pin_pre_divider_in, config_source_sel_in, bypass_n_in, factory_test_in,
                          output_gate_n_in, master_reset_n_in, ref_clk_in, vco_clk_in};
            pin_s2_ff <= pin_s1_ff;
        end
    end

    assign {sync_m, sync_na, sync_nb, sync_p, sync_src_sel, sync_bypass_n, sync_test,
            sync_gate, sync_mr_n, sync_ref, sync_vco} = pin_s2_ff;

    // Edge history for the reference, oscillator and master reset
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ref_s3_ff <= 1'b0;
            vco_s3_ff <= 1'b0;
            mr_s3_ff  <= 1'b0;
        end else begin
            ref_s3_ff <= sync_ref;
            vco_s3_ff <= sync_vco;
            mr_s3_ff  <= sync_mr_n;
        end
    end

    logic ref_rise;
    logic vco_rise;
    logic mr_rise;
    logic bypass_active;
    logic core_rst_n;

    assign ref_rise      = sync_ref && !ref_s3_ff;
    assign vco_rise      = sync_vco && !vco_s3_ff;
    assign mr_rise       = sync_mr_n && !mr_s3_ff;
    assign bypass_active = !sync_bypass_n;
    // Master reset clears the output path at once, without a clock edge
    assign core_rst_n    = rst_n_in && master_reset_n_in;

    // Post-divider code to half-period count, codes above five saturate
    function automatic logic [6:0] na_half(input logic [2:0] code);
        logic [2:0] c;
        c = (code > `SD_NA_CODE_MAX) ? `SD_NA_CODE_MAX : code;
        na_half = 7'h01 << c;
    endfunction

    // High configuration register image
    function automatic logic [7:0] pack_high(input logic [9:0] m, input logic [2:0] na,
                                             input logic nb, input logic p, input logic lk);
        pack_high = 8'h00;
        pack_high[`SD_HI_M_MSB:`SD_HI_M_LSB]   = m[9:8];
        pack_high[`SD_HI_NA_MSB:`SD_HI_NA_LSB] = na;
        pack_high[`SD_HI_NB]                   = nb;
        pack_high[`SD_HI_P]                    = p;
        pack_high[`SD_HI_LOCK]                 = lk;
    endfunction

    logic [7:0] cfg_low_ff;
    logic [7:0] cfg_high_ff;
    logic [9:0] m_ff;
    logic [2:0] na_ff;
    logic       nb_ff;
    logic       p_ff;
    logic       locked;
    logic       fb_phase;
    logic       cmd_wr;
    logic       cmd_up;
    logic       cmd_down;
    logic       cmd_load;
    logic       cmd_capture;

    assign cmd_wr      = reg_wr_in && reg_addr_in == `SD_ADDR_COMMAND;
    assign cmd_up      = cmd_wr && reg_wdata_in[3:0] == `SD_CMD_STEP_UP;
    assign cmd_down    = cmd_wr && reg_wdata_in[3:0] == `SD_CMD_STEP_DOWN;
    assign cmd_load    = cmd_wr && reg_wdata_in[3:0] == `SD_CMD_LOAD;
    assign cmd_capture = cmd_wr && reg_wdata_in[3:0] == `SD_CMD_CAPTURE;

    // Active dividers: startup load wins, then pins in parallel mode, then commands.
    // Commands that change dividers are ignored in parallel mode so pins stay in charge.
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            m_ff  <= `SD_M_RST;
            na_ff <= `SD_NA_RST;
            nb_ff <= `SD_NB_RST;
            p_ff  <= `SD_P_RST;
        end else if (mr_rise || !sync_src_sel) begin
            m_ff  <= sync_m;
            na_ff <= sync_na;
            nb_ff <= sync_nb;
            p_ff  <= sync_p;
        end else if (cmd_up) begin
            m_ff <= 10'(m_ff + 1'b1);
        end else if (cmd_down) begin
            m_ff <= 10'(m_ff - 1'b1);
        end else if (cmd_load) begin
            m_ff  <= {cfg_high_ff[`SD_HI_M_MSB:`SD_HI_M_LSB], cfg_low_ff};
            na_ff <= cfg_high_ff[`SD_HI_NA_MSB:`SD_HI_NA_LSB];
            nb_ff <= cfg_high_ff[`SD_HI_NB];
            p_ff  <= cfg_high_ff[`SD_HI_P];
        end
    end

    // Configuration registers; capture copies active dividers and takes priority
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg_low_ff  <= `SD_CFG_LOW_RST;
            cfg_high_ff <= `SD_CFG_HIGH_RST;
        end else if (cmd_capture) begin
            cfg_low_ff  <= m_ff[7:0];
            cfg_high_ff <= pack_high(m_ff, na_ff, nb_ff, p_ff, locked);
        end else if (reg_wr_in && reg_addr_in == `SD_ADDR_CFG_LOW) begin
            cfg_low_ff <= reg_wdata_in;
        end else if (reg_wr_in && reg_addr_in == `SD_ADDR_CFG_HIGH) begin
            cfg_high_ff <= reg_wdata_in;
        end
    end

    // Read port answers one cycle later; parallel mode shows the live setting
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out  <= `SD_RDATA_NONE;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                case (reg_addr_in)
                    `SD_ADDR_CFG_LOW:   reg_rdata_out <= sync_src_sel ? cfg_low_ff : m_ff[7:0];
                    `SD_ADDR_CFG_HIGH: begin
                        reg_rdata_out <= sync_src_sel
                            ? {cfg_high_ff[7:1], locked}
                            : pack_high(m_ff, na_ff, nb_ff, p_ff, locked);
                    end
                    `SD_ADDR_SIGNATURE: reg_rdata_out <= `SD_SIGNATURE_VAL;
                    default:            reg_rdata_out <= `SD_RDATA_NONE;
                endcase
            end
        end
    end

    // Output source: reference in bypass, oscillator with the loop running
    logic       src_tick;
    logic [6:0] half_a;
    logic [7:0] half_b;

    assign src_tick = bypass_active ? ref_rise : vco_rise;
    assign half_a   = na_half(na_ff);
    // Secondary runs at the primary rate or half of it; one bit wider so divide by 128 fits
    assign half_b   = nb_ff ? {half_a, 1'b0} : {1'b0, half_a};

    clk_out_divider #(
        .HALF_W (7)
    ) u_primary (
        .clock_in  (clock_in),
        .rst_n_in  (core_rst_n),
        .tick_in   (src_tick),
        .half_in   (half_a),
        .gate_in   (sync_gate[0]),
        .out_p_out (primary_out_pair_p_out),
        .out_n_out (primary_out_pair_n_out)
    );

    clk_out_divider #(
        .HALF_W (8)
    ) u_secondary (
        .clock_in  (clock_in),
        .rst_n_in  (core_rst_n),
        .tick_in   (src_tick),
        .half_in   (half_b),
        .gate_in   (sync_gate[1]),
        .out_p_out (secondary_out_pair_p_out),
        .out_n_out (secondary_out_pair_n_out)
    );

    // Lock acquisition restarts whenever master reset is released
    loop_lock_detect #(
        .CONFIRM (LOCK_CONFIRM)
    ) u_lock (
        .clock_in     (clock_in),
        .rst_n_in     (core_rst_n),
        .ref_tick_in  (ref_rise),
        .vco_tick_in  (vco_rise),
        .pre_sel_in   (p_ff),
        .feedback_in  (m_ff),
        .locked_out   (locked),
        .fb_phase_out (fb_phase)
    );

    // Lock pin doubles as a test output in bypass or factory test mode
    always_ff @(posedge clock_in or negedge core_rst_n) begin
        if (!core_rst_n) begin
            lock_out      <= 1'b0;
            test_mode_out <= 1'b0;
        end else begin
            lock_out      <= (bypass_active || sync_test) ? fb_phase : locked;
            test_mode_out <= sync_test;
        end
    end

    // Active divider status
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            active_feedback_out               <= `SD_M_RST;
            active_primary_post_divider_out   <= `SD_NA_RST;
            active_secondary_post_divider_out <= `SD_NB_RST;
            active_pre_divider_out            <= `SD_P_RST;
        end else begin
            active_feedback_out               <= m_ff;
            active_primary_post_divider_out   <= na_ff;
            active_secondary_post_divider_out <= nb_ff;
            active_pre_divider_out            <= p_ff;
        end
    end

    // Checks
    sequence serial_cmd(logic hit);
        hit && sync_src_sel && !mr_rise;
    endsequence

    AST_MR_CAPTURE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        mr_rise |=> m_ff == $past(sync_m) && na_ff == $past(sync_na) && p_ff == $past(sync_p))
        else $error("startup load missed the pins");

    AST_PARALLEL_FOLLOW: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        !sync_src_sel |=> m_ff == $past(sync_m) && nb_ff == $past(sync_nb))
        else $error("dividers did not follow pins");

    AST_STEP_UP: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        serial_cmd(cmd_up) |=> m_ff == 10'($past(m_ff) + 1'b1))
        else $error("step up did not add one");

    AST_STEP_DOWN: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        serial_cmd(cmd_down) |=> m_ff == 10'($past(m_ff) - 1'b1))
        else $error("step down did not subtract one");

    AST_LOAD: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        serial_cmd(cmd_load) |=> m_ff[7:0] == $past(cfg_low_ff) && na_ff == $past(cfg_high_ff[5:3]))
        else $error("load did not copy registers");

    AST_CAPTURE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        cmd_capture |=> cfg_low_ff == $past(m_ff[7:0]))
        else $error("capture did not copy dividers");

    AST_READBACK: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (reg_rd_in && reg_addr_in == `SD_ADDR_CFG_LOW && !sync_src_sel)
        |=> reg_rvalid_out && reg_rdata_out == $past(m_ff[7:0]))
        else $error("parallel readback wrong");

    AST_TEST_ON_LOCK: assert property (@(posedge clock_in) disable iff (!core_rst_n)
        (bypass_active ##1 bypass_active) |-> lock_out == $past(fb_phase))
        else $error("lock pin not test output in bypass");

    AST_MR_OUT_LOW: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        !master_reset_n_in |-> !primary_out_pair_p_out && !secondary_out_pair_p_out && !lock_out)
        else $error("outputs active in master reset");

endmodule

/* verification/analog_clock_source.sv */
module analog_clock_source #(
    parameter int REF_HALF = 160,
    parameter int VCO_HALF = 80
) (
    output logic ref_clk_out,
    output logic vco_clk_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Free-running loop clocks, each phase two system cycles or more so no edge is missed
    initial ref_clk_out = 1'b0;
    initial vco_clk_out = 1'b0;
    always #(REF_HALF) ref_clk_out = ~ref_clk_out;
    always #(VCO_HALF) vco_clk_out = ~vco_clk_out;
endmodule

/* verification/synth_divider_output_control_tb.sv */
module synth_divider_output_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; $display("Error %s %h %h", n, e, g); end end
    logic       clock_in = 1'b0, rst_n_in = 1'b0, mr_n = 1'b0, ft = 1'b0, src = 1'b0, wr = 1'b0, rd = 1'b0, byp_n = 1'b1;
    logic [1:0] gate_n;
    logic [9:0] pin_m, act_m, m;
    logic [2:0] pin_na, act_na, na;
    logic       pin_nb, pin_p, act_nb, act_p, nb, p, pa_p, sb_p, lock, tmode, rvalid, ref_clk, vco_clk, sb_q;
    logic [7:0] addr, wdata, rdata, got;
    int         fails = 0, comparisons = 0, i, pa_hi, sb_hi, lk_hi;
    // Clock
    always #20 clock_in = ~clock_in;
    analog_clock_source src_model (.ref_clk_out(ref_clk), .vco_clk_out(vco_clk));
    synth_divider_output_control #(.LOCK_CONFIRM(2)) DUT (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .master_reset_n_in(mr_n), .bypass_n_in(byp_n),
        .factory_test_in(ft), .config_source_sel_in(src), .output_gate_n_in(gate_n), .ref_clk_in(ref_clk),
        .vco_clk_in(vco_clk), .pin_feedback_in(pin_m), .pin_primary_post_divider_in(pin_na),
        .pin_secondary_post_divider_in(pin_nb), .pin_pre_divider_in(pin_p), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .primary_out_pair_p_out(pa_p), .primary_out_pair_n_out(), .secondary_out_pair_p_out(sb_p),
        .secondary_out_pair_n_out(), .lock_out(lock), .test_mode_out(tmode), .active_feedback_out(act_m),
        .active_primary_post_divider_out(act_na), .active_secondary_post_divider_out(act_nb),
        .active_pre_divider_out(act_p));
    // One-cycle strobe; read data taken while rvalid stands
    task automatic reg_op(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        #2;
        {wr, rd, addr, wdata} = {w, ~w, a, d};
        @(posedge clock_in);
        #2;
        {wr, rd, got} = {2'h0, rdata};
        if (!w) `CHK("rvalid", 1'b1, rvalid)
    endtask
    // Active copy trails the internal setting by one cycle, so allow three
    task automatic chk_act(input logic [9:0] em, input logic [2:0] ena, input logic enb, input logic ep);
        repeat (3) @(posedge clock_in);
        #2;
        `CHK("active", {em, ena, enb, ep}, {act_m, act_na, act_nb, act_p})
    endtask
    task automatic print_verdict;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (30000) @(posedge clock_in);
        fails++;
        print_verdict();
    end
    // Main sequence
    initial begin
        void'($urandom(50730));
        {gate_n, addr, wdata} = {2'h3, 16'h0000};
        {pin_m, pin_na, pin_nb, pin_p} = 15'($urandom);
        repeat (2) @(posedge clock_in);
        #2 rst_n_in = 1'b1;
        repeat (4) @(posedge clock_in);
        #2 mr_n = 1'b1;
        chk_act(pin_m, pin_na, pin_nb, pin_p);
        reg_op(1'b0, 8'h00, 8'h00);
        `CHK("readback", pin_m[7:0], got)
        reg_op(1'b0, 8'h08, 8'h00);
        `CHK("signature", 8'hA5, got)
        reg_op(1'b0, 8'h05, 8'h00);
        `CHK("unmapped", 8'h00, got)
        reg_op(1'b1, 8'hF0, 8'h01);
        chk_act(pin_m, pin_na, pin_nb, pin_p);
        {src, ft} = 2'h3;
        // Boundary feedback values first, then random ones
        for (i = 0; i < 4; i++) begin
            m = (i == 0) ? 10'h001 : (i == 1) ? 10'h3FE : 10'($urandom_range(1022, 1));
            {na, nb, p} = 5'($urandom);
            reg_op(1'b1, 8'h00, m[7:0]);
            reg_op(1'b1, 8'h01, {m[9:8], na, nb, p, 1'b0});
            reg_op(1'b1, 8'hF0, 8'h04);
            chk_act(m, na, nb, p);
            reg_op(1'b1, 8'hF0, 8'hF1);
            chk_act(m + 10'h001, na, nb, p);
            reg_op(1'b1, 8'hF0, 8'h02);
            reg_op(1'b1, 8'hF0, 8'h02);
            chk_act(m - 10'h001, na, nb, p);
            reg_op(1'b1, 8'h00, ~m[7:0]);
            reg_op(1'b1, 8'hF0, 8'h08);
            reg_op(1'b0, 8'h00, 8'h00);
            `CHK("capture", 8'(m - 10'h001), got)
        end
        `CHK("test_mode", 1'b1, tmode)
        // Oscillator runs at twice the reference; with divide by 4 a window holds 8 oscillator edges,
        // so feedback 8 gives one pulse per window (lock) and feedback 3 gives two or three (no lock)
        ft = 1'b0;
        reg_op(1'b1, 8'h00, 8'h08);
        reg_op(1'b1, 8'h01, 8'h02);
        for (i = 0; i < 2; i++) begin
            reg_op(1'b1, 8'hF0, 8'h04);
            repeat (300) @(posedge clock_in);
            #2;
            `CHK("lock", i == 0, lock)
            reg_op(1'b1, 8'h00, 8'h03);
        end
        // Bypass: outputs from the reference, test signal from the feedback-divided oscillator; primary gated off
        {byp_n, gate_n} = 3'h2;
        repeat (600) @(posedge clock_in);
        #2 sb_q = sb_p;
        {pa_hi, sb_hi, lk_hi} = 96'h0;
        // Stopped output stays low; the other keeps running
        repeat (1200) begin
            @(posedge clock_in);
            #2;
            pa_hi += int'(pa_p);
            sb_hi += int'(sb_p && !sb_q);
            lk_hi += int'(lock);
            sb_q = sb_p;
        end
        `CHK("stopped", 0, pa_hi)
        // Reference period is 8 cycles, post-divider 2: one rise per 16 cycles
        `CHK("sb_rises", 75, sb_hi)
        // Feedback 3 toggles the test signal every 12 cycles, high half the time
        `CHK("test_out", 600, lk_hi)
        {pin_m, pin_na, pin_nb, pin_p} = 15'($urandom);
        @(posedge clock_in);
        #2 mr_n = 1'b0;
        #3;
        `CHK("reset_outputs", 4'h0, {pa_p, sb_p, lock, tmode})
        // Second release with the serial source selected must still take the pins
        repeat (4) @(posedge clock_in);
        #2 mr_n = 1'b1;
        repeat (2) @(posedge clock_in);
        chk_act(pin_m, pin_na, pin_nb, pin_p);
        print_verdict();
    end
endmodule
